// *** rtl/poc_col_table.sv ***
// Per-column offset table with one write port and two read ports
`timescale 1ns/1ps
module poc_col_table #(
    parameter int DEPTH = 64,
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [W-1:0] wr_code,
    input wire logic [$clog2(DEPTH)-1:0] bus_idx,
    output logic [W-1:0] bus_code,
    input wire logic [$clog2(DEPTH)-1:0] col_idx,
    output logic [W-1:0] col_code
);
    import poc_pkg::*;

    logic [W-1:0] mem_q [DEPTH];

    //------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= W'(TBL_RST);
            end
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_code;
        end
    end

    assign bus_code = mem_q[bus_idx];
    assign col_code = mem_q[col_idx];

endmodule

// *** rtl/poc_offset_regs.sv ***
// Offset calibration register bank: DC, per-column and final offsets
`timescale 1ns/1ps
module poc_offset_regs #(
    parameter int COL_W = 11
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic COL_STROBE,
    input wire logic [COL_W-1:0] COL_INDEX,
    output logic [poc_pkg::CODE_W-1:0] COL_DC_CODE,
    output logic [poc_pkg::CODE_W-1:0] COL_SEL_CODE,
    output logic signed [6:0] COL_OFFSET_SUM,
    output logic COL_OFFSET_VALID,
    output logic [poc_pkg::CODE_W-1:0] FINAL_OFFSET_CODE,
    output logic signed [7:0] FINAL_OFFSET_LSB
);
    import poc_pkg::*;

    logic [5:0] col_dc_q;
    logic [5:0] final_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [5:0] sel_q;
    logic signed [6:0] sum_q;
    logic sum_vld_q;
    logic signed [7:0] final_lsb_q;

    //------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------
    wire hit_dc = (REG_ADDR == ADDR_COL_DC);
    wire hit_final = (REG_ADDR == ADDR_FINAL);
    wire hit_tbl = tbl_hit(REG_ADDR);
    wire [5:0] tbl_bus_idx = REG_ADDR[5:0];
    wire [5:0] tbl_col_idx = COL_INDEX[5:0];
    wire [5:0] tbl_bus_code;
    wire [5:0] tbl_col_code;
    wire [5:0] wcode = REG_WDATA[5:0];

    wire [7:0] rdata_d = hit_dc ? {2'b00, col_dc_q} :
                         hit_final ? {2'b00, final_q} :
                         hit_tbl ? {2'b00, tbl_bus_code} : RDATA_UNMAPPED;

    //------------------------------------------------------------------
    // Offset arithmetic
    //------------------------------------------------------------------
    wire signed [6:0] dc_val = sm_to_int(col_dc_q);
    wire signed [6:0] ent_val = sm_to_int(tbl_col_code);
    wire signed [7:0] final_wide = 8'(sm_to_int(final_q));
    // Both terms at most 31, so seven bits never overflow
    wire signed [6:0] sum_d = 7'(dc_val + ent_val);
    wire signed [7:0] final_lsb_d = 8'(final_wide * signed'(8'(FINAL_STEP_LSB)));

    poc_col_table #(
        .DEPTH(TBL_DEPTH),
        .W(CODE_W)
    ) poc_col_table_i (
        .clk(CLK_SYS),
        .nrst(NRST),
        .wr_en(REG_WE && hit_tbl),
        .wr_idx(tbl_bus_idx),
        .wr_code(wcode),
        .bus_idx(tbl_bus_idx),
        .bus_code(tbl_bus_code),
        .col_idx(tbl_col_idx),
        .col_code(tbl_col_code)
    );

    //------------------------------------------------------------------
    // Setting registers
    //------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            col_dc_q <= COL_DC_RST;
            final_q <= FINAL_RST;
        end else begin
            if (REG_WE && hit_dc) begin
                col_dc_q <= wcode;
            end
            if (REG_WE && hit_final) begin
                final_q <= wcode;
            end
        end
    end

    //------------------------------------------------------------------
    // Read port
    //------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= RDATA_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= REG_RE ? rdata_d : rdata_q;
            rvalid_q <= REG_RE;
        end
    end

    //------------------------------------------------------------------
    // Column path (pre-gain) and final path (pre-converter)
    //------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sel_q <= TBL_RST;
            sum_q <= '0;
            sum_vld_q <= 1'b0;
            final_lsb_q <= '0;
        end else begin
            if (COL_STROBE) begin
                sel_q <= tbl_col_code;
                sum_q <= sum_d;
            end
            sum_vld_q <= COL_STROBE;
            final_lsb_q <= final_lsb_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign COL_DC_CODE = col_dc_q;
    assign COL_SEL_CODE = sel_q;
    assign COL_OFFSET_SUM = sum_q;
    assign COL_OFFSET_VALID = sum_vld_q;
    assign FINAL_OFFSET_CODE = final_q;
    assign FINAL_OFFSET_LSB = final_lsb_q;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    logic after_rst_q;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            after_rst_q <= 1'b0;
        end else begin
            after_rst_q <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    chk_dc_write_lands: assert property (
        (REG_WE && REG_ADDR == ADDR_COL_DC) |=> COL_DC_CODE == $past(REG_WDATA[5:0]))
        else $error("column DC offset write not stored");
    chk_dc_reset_zero: assert property (
        !after_rst_q |-> COL_DC_CODE == 6'h00 && FINAL_OFFSET_CODE == 6'h00)
        else $error("offset settings not zero after reset");
    chk_final_path_stable: assert property (
        !(REG_WE && REG_ADDR == ADDR_FINAL) ##1 COL_STROBE |=> $stable(FINAL_OFFSET_LSB))
        else $error("final offset moved without a write");
    chk_tbl_readback: assert property (
        (REG_WE && tbl_hit(REG_ADDR)) ##1
        (REG_RE && !REG_WE && REG_ADDR == $past(REG_ADDR))
        |=> REG_RDATA == {2'b00, $past(REG_WDATA[5:0], 2)})
        else $error("per-column entry readback mismatch");
    chk_col_select: assert property (
        (REG_WE && REG_ADDR == 8'hbf) ##1
        (COL_STROBE && COL_INDEX[5:0] == 6'h3f && !(REG_WE && tbl_hit(REG_ADDR)))
        |=> COL_SEL_CODE == $past(REG_WDATA[5:0], 2))
        else $error("column 63 did not pick entry 0xbf");
    chk_col_sum: assert property (
        COL_STROBE |=> COL_OFFSET_VALID &&
        COL_OFFSET_SUM == sm_to_int($past(COL_DC_CODE)) + sm_to_int(COL_SEL_CODE))
        else $error("column offset sum wrong");
    chk_final_write: assert property (
        (REG_WE && REG_ADDR == ADDR_FINAL) |=> FINAL_OFFSET_CODE == $past(REG_WDATA[5:0])
        ##1 FINAL_OFFSET_LSB == 8'(sm_to_int($past(FINAL_OFFSET_CODE)) * 4))
        else $error("final offset write not applied");
    chk_final_sign: assert property (
        ##1 (FINAL_OFFSET_LSB < 0) |-> $past(FINAL_OFFSET_CODE[5]))
        else $error("final offset sign bit ignored");
    chk_final_span: assert property (
        FINAL_OFFSET_LSB <= FINAL_SPAN_LSB && FINAL_OFFSET_LSB >= -FINAL_SPAN_LSB &&
        FINAL_OFFSET_LSB[1:0] == 2'b00)
        else $error("final offset outside span or off step");
    chk_read_upper_zero: assert property (
        REG_RVALID |-> REG_RDATA[7:6] == 2'b00)
        else $error("unused bits read nonzero");

    //------------------------------------------------------------------
    // Hold and strobe checks
    //------------------------------------------------------------------
    chk_dc_hold: assert property (
        !(REG_WE && hit_dc) |=> $stable(COL_DC_CODE))
        else $error("column DC offset changed without a write");
    chk_final_hold: assert property (
        !(REG_WE && hit_final) |=> $stable(FINAL_OFFSET_CODE))
        else $error("final offset changed without a write");
    chk_read_strobe: assert property (
        REG_RE |=> REG_RVALID)
        else $error("read not answered in one cycle");
    chk_read_quiet: assert property (
        !REG_RE |=> !REG_RVALID)
        else $error("read valid without a read");
    chk_rdata_holds: assert property (
        !REG_RE |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
    chk_unmapped_read: assert property (
        (REG_RE && !hit_dc && !hit_final && !hit_tbl) |=> REG_RDATA == RDATA_UNMAPPED)
        else $error("unmapped address read nonzero");
    chk_col_quiet: assert property (
        !COL_STROBE |=> !COL_OFFSET_VALID)
        else $error("column valid without a strobe");
    chk_sel_holds: assert property (
        !COL_STROBE |=> $stable(COL_SEL_CODE) && $stable(COL_OFFSET_SUM))
        else $error("column offset changed without a strobe");
    chk_sum_range: assert property (
        COL_OFFSET_SUM <= 7'sd62 && COL_OFFSET_SUM >= -7'sd62)
        else $error("column offset sum out of range");
    chk_final_lsb_follows: assert property (
        1'b1 |=> FINAL_OFFSET_LSB == 8'(sm_to_int($past(FINAL_OFFSET_CODE)) * 4))
        else $error("final offset scaling wrong");

    cov_final_neg: cover property (REG_WE && REG_ADDR == ADDR_FINAL && REG_WDATA[5]);
    cov_col_wrap: cover property (COL_STROBE && COL_INDEX[5:0] == 6'h3f ##1
        COL_STROBE && COL_INDEX[5:0] == 6'h00);
    cov_sum_neg: cover property (COL_OFFSET_VALID && COL_OFFSET_SUM < 0);
    cov_back_readback: cover property (REG_WE && hit_tbl ##1 REG_RE && !REG_WE);
    cov_dc_neg: cover property (REG_WE && hit_dc && REG_WDATA[5]);

endmodule

// *** rtl/poc_pkg.sv ***
// Constants and helpers shared by the offset calibration register bank
//----------------------------------------------------------------------
// Functional notes
// - Column DC offset is six-bit sign-magnitude.
// - Column DC offset resets to zero.
// - DC offset before gain, final offset after.
// - Sixty-four writable per-column offsets, same layout.
// - Column uses entry 0x80 plus index mod 64.
// - Final offset drives last pre-converter adjustment.
// - Final offset is six-bit sign-magnitude field.
// - Final step is four LSB per code, span 124.
//----------------------------------------------------------------------
package poc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_COL_DC = 8'h20;
    localparam logic [7:0] ADDR_FINAL = 8'h23;
    localparam logic [7:0] ADDR_TBL_BASE = 8'h80;
    localparam int TBL_DEPTH = 64;
    localparam int TBL_IDX_W = 6;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int CODE_W = 6;
    localparam int SIGN_BIT = 5;
    localparam int MAG_MSB = 4;
    localparam logic [5:0] COL_DC_RST = 6'h00;
    localparam logic [5:0] FINAL_RST = 6'h00;
    localparam logic [5:0] TBL_RST = 6'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Final offset scaling
    // ------------------------------------------------------------------
    localparam int FINAL_STEP_LSB = 4;
    localparam int FINAL_SPAN_LSB = 124;

    // Sign-magnitude code to two's complement, range -31..31
    function automatic logic signed [6:0] sm_to_int(input logic [5:0] code);
        logic signed [6:0] mag;
        mag = signed'({2'b00, code[MAG_MSB:0]});
        return code[SIGN_BIT] ? -mag : mag;
    endfunction

    // Address lies inside the per-column table window
    function automatic logic tbl_hit(input logic [7:0] addr);
        return (addr >= ADDR_TBL_BASE) && ({1'b0, addr} < ({1'b0, ADDR_TBL_BASE} + 9'h040));
    endfunction

endpackage

// *** tb/poc_host.sv ***
// Host controller model driving the register port
`timescale 1ns/1ps
module poc_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic we,
    output logic re,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        we = 1'b0;
        re = 1'b0;
    end
    // Raw codes only, gain scaling is the caller's business
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        we = 1'b1;
        @(posedge clk);
        #1;
        we = 1'b0;
        wdata = ~d;
        addr = ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        addr = a;
        re = 1'b1;
        @(posedge clk);
        #1;
        re = 1'b0;
        addr = ~a;
        d = rdata;
        v = rvalid;
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
        output logic v);
        @(posedge clk);
        #1;
        addr = a;
        wdata = wd;
        we = 1'b1;
        @(posedge clk);
        #1;
        we = 1'b0;
        re = 1'b1;
        @(posedge clk);
        #1;
        re = 1'b0;
        addr = ~a;
        wdata = ~wd;
        d = rdata;
        v = rvalid;
    endtask
endmodule

// *** tb/poc_offset_regs_bench.sv ***
// Self-checking bench for the offset calibration register bank
`timescale 1ns/1ps
module poc_offset_regs_bench;
    import poc_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic col_strobe = 1'b0;
    logic [10:0] col_index = 11'h000;
    logic [7:0] addr, wdata, rdata, d;
    logic we, re, rvalid, valid, v;
    logic [5:0] dc_code, sel, fin;
    logic signed [6:0] sum;
    logic signed [7:0] fin_lsb;
    int errors = 0;
    int total_checks = 0;
    logic [5:0] fcodes [5] = '{6'h17, 6'h37, 6'h1f, 6'h3f, 6'h20};
    logic [10:0] cols [6] = '{11'h000, 11'h001, 11'h03f, 11'h040, 11'h041, 11'h7ff};
    always #20 clk_sys = ~clk_sys;
    poc_host poc_host_i (.clk(clk_sys), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .rvalid(rvalid));
    poc_offset_regs poc_offset_regs_i (.CLK_SYS(clk_sys), .NRST(nrst), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .COL_STROBE(col_strobe), .COL_INDEX(col_index),
        .COL_DC_CODE(dc_code), .COL_SEL_CODE(sel), .COL_OFFSET_SUM(sum),
        .COL_OFFSET_VALID(valid), .FINAL_OFFSET_CODE(fin), .FINAL_OFFSET_LSB(fin_lsb));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] smv(input logic [5:0] c);
        return c[5] ? 8'h00 - {3'b000, c[4:0]} : {3'b000, c[4:0]};
    endfunction
    function automatic logic [5:0] ent(input logic [5:0] i);
        return i ^ 6'h2a;
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        poc_host_i.rd(a, d, v);
        cmp({7'h00, v}, 8'h01, "read valid");
        cmp(d, exp, "read data");
    endtask
    task automatic col(input logic [10:0] idx, input logic [5:0] dc);
        @(posedge clk_sys);
        #1;
        col_strobe = 1'b1;
        col_index = idx;
        @(posedge clk_sys);
        #1;
        col_strobe = 1'b0;
        col_index = ~idx;
        cmp({7'h00, valid}, 8'h01, "column valid");
        cmp({2'b00, sel}, {2'b00, ent(idx[5:0])}, "column entry");
        cmp({sum[6], sum}, smv(dc) + smv(ent(idx[5:0])), "column sum");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        cmp({2'b00, dc_code}, 8'h00, "dc after reset");
        rdchk(ADDR_COL_DC, 8'h00);
        rdchk(ADDR_FINAL, 8'h00);
        rdchk(8'hbf, 8'h00);
        $display("test reset done");
    endtask
    task automatic test_dc();
        poc_host_i.wr(ADDR_COL_DC, 8'hff);
        cmp({2'b00, dc_code}, 8'h3f, "dc code");
        rdchk(ADDR_COL_DC, 8'h3f);
        poc_host_i.wr(8'h21, 8'h11);
        rdchk(8'h21, 8'h00);
        poc_host_i.wr(ADDR_COL_DC, 8'hc5);
        cmp({2'b00, dc_code}, 8'h05, "dc code");
        $display("test dc done");
    endtask
    task automatic test_final();
        for (int i = 0; i < 5; i++) begin
            poc_host_i.wr(ADDR_FINAL, {2'b10, fcodes[i]});
            @(posedge clk_sys);
            #1;
            cmp({2'b00, fin}, {2'b00, fcodes[i]}, "final code");
            cmp(fin_lsb, smv(fcodes[i]) << 2, "final lsb");
            cmp({2'b00, dc_code}, 8'h05, "dc untouched");
        end
        rdchk(ADDR_FINAL, 8'h20);
        $display("test final done");
    endtask
    task automatic test_table();
        for (int i = 0; i < 64; i++) begin
            poc_host_i.wr(ADDR_TBL_BASE + 8'(i), {2'b11, ent(6'(i))});
        end
        for (int i = 0; i < 64; i++) begin
            rdchk(ADDR_TBL_BASE + 8'(i), {2'b00, ent(6'(i))});
        end
        for (int j = 0; j < 6; j++) begin
            col(cols[j], 6'h05);
        end
        poc_host_i.wr(ADDR_COL_DC, 8'h3f);
        col(11'h43f, 6'h3f);
        $display("test table done");
    endtask
    task automatic test_back();
        poc_host_i.wr_rd(8'h85, 8'h2c, d, v);
        cmp({7'h00, v}, 8'h01, "valid after write");
        cmp(d, 8'h2c, "back to back readback");
        poc_host_i.wr(8'hbf, 8'h09);
        col_strobe = 1'b1;
        col_index = 11'h03f;
        @(posedge clk_sys);
        #1;
        col_index = 11'h040;
        cmp({2'b00, sel}, 8'h09, "entry 63 just written");
        cmp({sum[6], sum}, smv(6'h3f) + smv(6'h09), "sum with new entry");
        @(posedge clk_sys);
        #1;
        col_strobe = 1'b0;
        cmp({2'b00, sel}, {2'b00, ent(6'h00)}, "wrap to first entry");
        @(posedge clk_sys);
        #1;
        cmp({7'h00, valid}, 8'h00, "valid one cycle");
        nrst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        cmp({2'b00, fin}, 8'h00, "final after second reset");
        cmp({2'b00, dc_code}, 8'h00, "dc after second reset");
        rdchk(8'hbf, 8'h00);
        $display("test back done");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        test_reset();
        test_dc();
        test_final();
        test_table();
        test_back();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        complete_run();
    end
endmodule
